//--- pkg/swp_pkg.sv
// package: constants and types for the single-wire pulse slave
package swp_pkg;
  // ----------------------------------------------------------------
  // clock and printed times
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  // times in tenths of a microsecond, as printed
  localparam int IDLE_MIN_TIME_DUS           = 110;
  localparam int MASTER_SHORT_PULSE_MIN_DUS  = 118;
  localparam int MASTER_SHORT_PULSE_MAX_DUS  = 170;
  localparam int MASTER_LONG_PULSE_MIN_DUS   = 354;
  localparam int MASTER_LONG_PULSE_MAX_DUS   = 489;
  localparam int EDGE_DETECT_WINDOW_DUS      = 96;
  localparam int SLAVE_ONE_PULSE_MIN_DUS     = 283;
  localparam int SLAVE_ONE_PULSE_MAX_DUS     = 383;
  localparam int START_PULSE_MIN_DUS         = 800;
  localparam int START_PULSE_MAX_DUS         = 1090;
  localparam int ATTENTION_PULSE_MIN_DUS     = 1650;
  localparam int ATTENTION_PULSE_MAX_DUS     = 2280;
  localparam int RESET_PULSE_MIN_DUS         = 3540;
  // cycles per tenth of a microsecond
  localparam int CYC_PER_DUS = CLK_MHZ / 10;
  // ----------------------------------------------------------------
  // cycle counts (integer division, so every half rounds down)
  // ----------------------------------------------------------------
  localparam int CNT_W = 20;
  localparam int IDLE_CYC      = IDLE_MIN_TIME_DUS * CYC_PER_DUS;
  // drive lengths chosen mid-range, reset drive at its minimum
  localparam int SLAVE_ONE_CYC =
    (SLAVE_ONE_PULSE_MIN_DUS + SLAVE_ONE_PULSE_MAX_DUS) / 2 * CYC_PER_DUS;
  localparam int ATTN_CYC      =
    (ATTENTION_PULSE_MIN_DUS + ATTENTION_PULSE_MAX_DUS) / 2 * CYC_PER_DUS;
  localparam int RESET_CYC     = RESET_PULSE_MIN_DUS * CYC_PER_DUS;
  // react well inside the detection window
  localparam int REACT_CYC     = EDGE_DETECT_WINDOW_DUS * CYC_PER_DUS / 4;
  // classification thresholds between the symbol ranges
  localparam int THR_ONE   =
    (MASTER_SHORT_PULSE_MAX_DUS + SLAVE_ONE_PULSE_MIN_DUS) / 2 * CYC_PER_DUS;
  localparam int THR_START =
    (MASTER_LONG_PULSE_MAX_DUS + START_PULSE_MIN_DUS) / 2 * CYC_PER_DUS;
  localparam int THR_ATTN  =
    (START_PULSE_MAX_DUS + ATTENTION_PULSE_MIN_DUS) / 2 * CYC_PER_DUS;
  localparam int THR_RESET =
    (ATTENTION_PULSE_MAX_DUS + RESET_PULSE_MIN_DUS) / 2 * CYC_PER_DUS;
  // data bits needed after reset before attention
  localparam logic [3:0] BITS_AFTER_RESET = 4'hE;
  // ----------------------------------------------------------------
  // symbol codes and state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SWP_SYM_ZERO  = 3'h0,
    SWP_SYM_ONE   = 3'h1,
    SWP_SYM_START = 3'h2,
    SWP_SYM_ATTN  = 3'h3,
    SWP_SYM_RESET = 3'h4
  } swp_sym_e;
  typedef enum logic [4:0] {
    SWP_ST_PWRUP = 5'h01,
    SWP_ST_WAIT  = 5'h02,
    SWP_ST_IDLE  = 5'h04,
    SWP_ST_LOW   = 5'h08,
    SWP_ST_DRIVE = 5'h10
  } swp_state_e;
  // two selectable device numbers
  localparam logic [2:0] DEV_NUM_PIN_LOW  = 3'h1;
  localparam logic [2:0] DEV_NUM_PIN_HIGH = 3'h2;
endpackage : swp_pkg

//--- logic/swp_timer.sv
// file: saturating cycle counter used to time line levels
`timescale 1ns/1ps
`default_nettype none
module swp_timer
  import swp_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             clear,
  output logic [CNT_W-1:0]      count
);
  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  assign count_next = clear ? '0 :
                      (count_reg == CNT_MAX) ? count_reg : count_reg + 1'b1;
  // count, saturate at top
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
  assign count = count_reg;
endmodule : swp_timer
`default_nettype wire

//--- logic/swp_classify.sv
// file: maps a low-pulse length onto a symbol code
`timescale 1ns/1ps
`default_nettype none
module swp_classify
  import swp_pkg::*;
(
  input  wire logic [CNT_W-1:0] low_len,
  output swp_sym_e              sym
);
  // ----------------------------------------------------------------
  // threshold compare
  // ----------------------------------------------------------------
  wire ge_one   = low_len >= CNT_W'(THR_ONE);
  wire ge_start = low_len >= CNT_W'(THR_START);
  wire ge_attn  = low_len >= CNT_W'(THR_ATTN);
  wire ge_reset = low_len >= CNT_W'(THR_RESET);
  // longest matching symbol wins
  assign sym = ge_reset ? SWP_SYM_RESET :
               ge_attn  ? SWP_SYM_ATTN  :
               ge_start ? SWP_SYM_START :
               ge_one   ? SWP_SYM_ONE   : SWP_SYM_ZERO;
endmodule : swp_classify
`default_nettype wire

//--- logic/swp_slave.sv
// file: bit-level slave end of the single-wire pulse bus
`timescale 1ns/1ps
`default_nettype none
module swp_slave
  import swp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       line_in,
  output logic            line_out,
  output logic            line_oe,
  input  wire logic       addr_sel,
  input  wire logic       tx_valid,
  input  wire logic       tx_bit,
  output logic            tx_taken,
  input  wire logic       fresh_data,
  output logic            rx_valid,
  output logic            rx_bit,
  output logic            rx_start,
  output logic            rx_reset,
  output logic            rx_attn,
  output logic            bus_idle,
  output logic [2:0]      dev_num
);
  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  swp_state_e       state_reg;
  swp_state_e       state_next;
  logic             line_d_reg;
  logic             drive_reg;
  logic             drive_next;
  logic [CNT_W-1:0] drv_cnt_reg;
  logic [CNT_W-1:0] drv_cnt_next;
  logic [3:0]       bits_seen_reg;
  logic             attn_pend_reg;
  logic             read_one_reg;
  logic             rx_valid_reg;
  logic             rx_bit_reg;
  logic             rx_start_reg;
  logic             rx_reset_reg;
  logic             rx_attn_reg;
  logic             tx_taken_reg;
  logic             idle_reg;
  logic [2:0]       dev_num_reg;
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] high_cnt;
  swp_sym_e         sym;
  // ----------------------------------------------------------------
  // line timers and classifier
  // ----------------------------------------------------------------
  swp_timer u_low_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .clear (line_in),
    .count (low_cnt)
  );
  swp_timer u_high_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .clear (!line_in),
    .count (high_cnt)
  );
  swp_classify u_classify (
    .low_len (low_cnt),
    .sym     (sym)
  );
  // ----------------------------------------------------------------
  // decoded conditions
  // ----------------------------------------------------------------
  wire idle_now   = line_in && (high_cnt >= CNT_W'(IDLE_CYC));
  wire fall       = line_d_reg && !line_in;
  wire rise       = !line_d_reg && line_in;
  wire may_attn   = (bits_seen_reg == BITS_AFTER_RESET);
  wire in_window  = (low_cnt == CNT_W'(REACT_CYC));
  wire drv_done   = (drv_cnt_reg == '0);
  wire drive_rst  = (state_reg == SWP_ST_PWRUP);
  wire is_data    = (sym == SWP_SYM_ZERO) || (sym == SWP_SYM_ONE);
  wire start_attn = attn_pend_reg && may_attn &&
                    ((state_reg == SWP_ST_IDLE && idle_now) ||
                     (state_reg == SWP_ST_LOW && in_window));
  wire start_one  = (state_reg == SWP_ST_LOW) && in_window &&
                    tx_valid && tx_bit && !start_attn;
  wire take_tx    = (state_reg == SWP_ST_LOW) && in_window && tx_valid;
  wire pulse_end  = rise && (state_reg == SWP_ST_LOW ||
                             state_reg == SWP_ST_DRIVE);
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next   = state_reg;
    drive_next   = drive_reg;
    drv_cnt_next = drv_cnt_reg;
    if (!drv_done) begin
      drv_cnt_next = drv_cnt_reg - 1'b1;
    end
    case (state_reg)
      SWP_ST_PWRUP: begin
        // hold reset symbol for its full length
        drive_next = 1'b1;
        if (drv_done) begin
          drive_next = 1'b0;
          state_next = SWP_ST_WAIT;
        end
      end
      SWP_ST_WAIT: begin
        if (idle_now) begin
          state_next = SWP_ST_IDLE;
        end
      end
      SWP_ST_IDLE: begin
        if (start_attn) begin
          drive_next   = 1'b1;
          drv_cnt_next = CNT_W'(ATTN_CYC);
          state_next   = SWP_ST_DRIVE;
        end else if (fall) begin
          state_next = SWP_ST_LOW;
        end
      end
      SWP_ST_LOW: begin
        if (start_attn) begin
          drive_next   = 1'b1;
          drv_cnt_next = CNT_W'(ATTN_CYC - REACT_CYC);
          state_next   = SWP_ST_DRIVE;
        end else if (start_one) begin
          drive_next   = 1'b1;
          drv_cnt_next = CNT_W'(SLAVE_ONE_CYC - REACT_CYC);
          state_next   = SWP_ST_DRIVE;
        end else if (rise) begin
          state_next = SWP_ST_WAIT;
        end
      end
      SWP_ST_DRIVE: begin
        // stay until the line is back high so the pulse gets classified
        if (drv_done) begin
          drive_next = 1'b0;
        end
        if (rise) begin
          state_next = SWP_ST_WAIT;
        end
      end
      default: begin
        drive_next = 1'b0;
        state_next = SWP_ST_WAIT;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg   <= SWP_ST_PWRUP;
      drive_reg   <= 1'b1;
      drv_cnt_reg <= CNT_W'(RESET_CYC);
      line_d_reg  <= 1'b1;
    end else begin
      state_reg   <= state_next;
      drive_reg   <= drive_next;
      drv_cnt_reg <= drv_cnt_next;
      line_d_reg  <= line_in;
    end
  end
  // ----------------------------------------------------------------
  // attention request pending; new readings set, own attention clears
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      attn_pend_reg <= 1'b0;
    end else if (fresh_data) begin
      attn_pend_reg <= 1'b1;
    end else if (start_attn) begin
      attn_pend_reg <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // data bits counted since the last bus reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bits_seen_reg <= '0;
    end else if (pulse_end && sym == SWP_SYM_RESET) begin
      bits_seen_reg <= '0;
    end else if (pulse_end && is_data && !may_attn) begin
      bits_seen_reg <= bits_seen_reg + 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // remember a one being returned, for the read-back check
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      read_one_reg <= 1'b0;
    end else if (start_one) begin
      read_one_reg <= 1'b1;
    end else if (state_reg == SWP_ST_IDLE) begin
      read_one_reg <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // symbol reports at the rising edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_valid_reg <= 1'b0;
      rx_bit_reg   <= 1'b0;
      rx_start_reg <= 1'b0;
      rx_reset_reg <= 1'b0;
      rx_attn_reg  <= 1'b0;
      tx_taken_reg <= 1'b0;
    end else begin
      rx_valid_reg <= pulse_end && is_data;
      rx_bit_reg   <= pulse_end && (sym == SWP_SYM_ONE);
      rx_start_reg <= pulse_end && (sym == SWP_SYM_START);
      rx_reset_reg <= pulse_end && (sym == SWP_SYM_RESET);
      rx_attn_reg  <= pulse_end && (sym == SWP_SYM_ATTN);
      tx_taken_reg <= take_tx && !start_attn;
    end
  end
  // ----------------------------------------------------------------
  // idle flag and address pin capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      idle_reg    <= 1'b0;
      dev_num_reg <= DEV_NUM_PIN_LOW;
    end else begin
      idle_reg    <= idle_now;
      dev_num_reg <= addr_sel ? DEV_NUM_PIN_HIGH : DEV_NUM_PIN_LOW;
    end
  end
  // ----------------------------------------------------------------
  // outputs; open drain, so data is always low
  // ----------------------------------------------------------------
  assign line_out = 1'b0;
  assign line_oe  = drive_reg;
  assign rx_valid = rx_valid_reg;
  assign rx_bit   = rx_bit_reg;
  assign rx_start = rx_start_reg;
  assign rx_reset = rx_reset_reg;
  assign rx_attn  = rx_attn_reg;
  assign tx_taken = tx_taken_reg;
  assign bus_idle = idle_reg;
  assign dev_num  = dev_num_reg;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_pwrup_reset;
    @(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> line_oe [*8];
  endproperty
  a_pwrup_reset: assert property (p_pwrup_reset)
    else $error("no reset drive after power-up");
  property p_attn_gate;
    @(posedge clk) disable iff (!rst_b)
    ($rose(line_oe) && !$past(start_one)) |->
      $past(bits_seen_reg) == BITS_AFTER_RESET;
  endproperty
  a_attn_gate: assert property (p_attn_gate)
    else $error("attention before enough data bits");
  property p_attn_when;
    @(posedge clk) disable iff (!rst_b)
    $rose(line_oe) |->
      $past(idle_now) ||
      ($past(state_reg) == SWP_ST_LOW &&
       $past(low_cnt) == CNT_W'(REACT_CYC));
  endproperty
  a_attn_when: assert property (p_attn_when)
    else $error("attention outside idle or window");
  property p_one_drive;
    @(posedge clk) disable iff (!rst_b)
    start_one |=> line_oe [*8];
  endproperty
  a_one_drive: assert property (p_one_drive)
    else $error("read one not driven");
  property p_data_only;
    @(posedge clk) disable iff (!rst_b)
    rx_valid |-> !rx_start && !rx_reset && !rx_attn;
  endproperty
  a_data_only: assert property (p_data_only)
    else $error("long symbol reported as data");
  property p_start_report;
    @(posedge clk) disable iff (!rst_b)
    (pulse_end && sym == SWP_SYM_START) |=> rx_start && !rx_valid;
  endproperty
  a_start_report: assert property (p_start_report)
    else $error("start symbol not reported");
  property p_attn_not_start;
    @(posedge clk) disable iff (!rst_b)
    rx_attn |-> !rx_start;
  endproperty
  a_attn_not_start: assert property (p_attn_not_start)
    else $error("attention taken as start");
  property p_idle_flag;
    @(posedge clk) disable iff (!rst_b)
    !line_in |=> !bus_idle;
  endproperty
  a_idle_flag: assert property (p_idle_flag)
    else $error("idle while line low");
  property p_addr;
    @(posedge clk) disable iff (!rst_b)
    addr_sel |=> dev_num == DEV_NUM_PIN_HIGH;
  endproperty
  a_addr: assert property (p_addr)
    else $error("address select ignored");
  property p_pwrup_hold;
    @(posedge clk) disable iff (!rst_b)
    drive_rst |-> line_oe;
  endproperty
  a_pwrup_hold: assert property (p_pwrup_hold)
    else $error("power-up reset drive dropped early");
  property p_read_one_len;
    @(posedge clk) disable iff (!rst_b)
    (pulse_end && read_one_reg) |-> sym != SWP_SYM_ZERO;
  endproperty
  a_read_one_len: assert property (p_read_one_len)
    else $error("returned one decoded as zero");
  property p_attn_report;
    @(posedge clk) disable iff (!rst_b)
    (pulse_end && sym == SWP_SYM_ATTN) |=> rx_attn && !rx_valid;
  endproperty
  a_attn_report: assert property (p_attn_report)
    else $error("attention symbol not reported");
endmodule : swp_slave
`default_nettype wire

//--- tb/swp_master_model.sv
// file: behavioural bus master for the single-wire pulse slave bench
`timescale 1ns/1ps
`default_nettype none
module swp_master_model
  import swp_pkg::*;
(
  input  wire logic clk,
  input  wire logic line,
  output logic      drive_low
);
  // -------------------------------------------------------------
  // power-up reset, master side
  // -------------------------------------------------------------
  // own reset, longer than the device's, no upper limit
  initial begin
    drive_low = 1'b1;
    repeat (RESET_CYC + 500) @(negedge clk);
    drive_low = 1'b0;
  end

  // waits until the line has been high past the idle time
  task automatic wait_idle(output bit ok);
    int hi;
    int n;
    hi = 0;
    ok = 1'b0;
    for (n = 0; n < 200000 && !ok; n++) begin
      @(negedge clk);
      hi = line ? hi + 1 : 0;
      ok = (hi > IDLE_CYC + 8);
    end
  endtask : wait_idle

  // one master-timed low pulse; low_len is -1 on a hang
  task automatic pulse(input int len, output int low_len);
    bit ok;
    int n;
    wait_idle(ok);
    low_len = -1;
    if (ok) begin
      @(negedge clk);
      drive_low = 1'b1;
      repeat (len) @(negedge clk);
      drive_low = 1'b0;
      // bit decided from the moment the line returns high
      // the line is looked at on the edges after the release
      for (n = len; n < 400000 && low_len < 0; n++) begin
        @(negedge clk);
        if (line) low_len = n;
      end
    end
  endtask : pulse

  // watches for a low pulse from another party; -1 when none
  task automatic watch_low(input int max_wait, output int gap,
                           output int low_len);
    int n;
    gap = -1;
    low_len = -1;
    for (n = 0; n < max_wait && gap < 0; n++) begin
      @(negedge clk);
      if (!line) gap = n;
    end
    for (n = 0; n < 400000 && gap >= 0 && low_len < 0; n++) begin
      @(negedge clk);
      if (line) low_len = n + 1;
    end
  endtask : watch_low
endmodule : swp_master_model
`default_nettype wire

//--- tb/test_swp_slave.sv
// file: self-checking bench for the single-wire pulse slave
`timescale 1ns/1ps
`default_nettype none
module test_swp_slave;
  import swp_pkg::*;
  logic       clk;
  logic       rst_b;
  wire logic  line_in;
  logic       line_out;
  logic       line_oe;
  logic       addr_sel;
  logic       tx_valid;
  logic       tx_bit;
  logic       tx_taken;
  logic       fresh_data;
  logic       rx_valid;
  logic       rx_bit;
  logic       rx_start;
  logic       rx_reset;
  logic       rx_attn;
  logic       bus_idle;
  logic [2:0] dev_num;
  logic       m_drive;
  int         err_count = 0;
  int         tests_run = 0;
  int         n_valid = 0;
  int         n_start = 0;
  int         n_attn = 0;
  int         n_reset = 0;
  int         n_taken = 0;
  logic       last_bit;

  // wired-and line with pull-up
  assign line_in = !(line_oe | m_drive);

  swp_slave i_dut (
    .clk(clk), .rst_b(rst_b), .line_in(line_in), .line_out(line_out),
    .line_oe(line_oe), .addr_sel(addr_sel), .tx_valid(tx_valid),
    .tx_bit(tx_bit), .tx_taken(tx_taken), .fresh_data(fresh_data),
    .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_start(rx_start),
    .rx_reset(rx_reset), .rx_attn(rx_attn), .bus_idle(bus_idle),
    .dev_num(dev_num)
  );

  swp_master_model i_master (
    .clk(clk), .line(line_in), .drive_low(m_drive)
  );

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // counts the one-cycle event pulses mid-cycle
  always @(negedge clk) begin
    if (rx_valid === 1'b1) n_valid++;
    if (rx_valid === 1'b1) last_bit = rx_bit;
    if (rx_start === 1'b1) n_start++;
    if (rx_attn === 1'b1) n_attn++;
    if (rx_reset === 1'b1) n_reset++;
    if (tx_taken === 1'b1) n_taken++;
  end

  // -------------------------------------------------------------
  // report helpers
  // -------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // a bound that ran out ends the run
  task automatic guard(input bit ok);
    if (!ok) begin
      err_count++;
      tally_and_finish();
    end
  endtask : guard

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_power_up();
    int n;
    repeat (12) @(negedge clk);
    check("oe_in_reset", line_oe, 1'b1);
    check("line_out", line_out, 1'b0);
    check("dev_num_low", dev_num, DEV_NUM_PIN_LOW);
    rst_b = 1'b1;
    repeat (RESET_CYC - 500) @(negedge clk);
    check("oe_reset_drive", line_oe, 1'b1);
    for (n = 0; n < 1000 && line_oe !== 1'b0; n++) @(negedge clk);
    guard(n < 1000);
    check("reset_len", n > 500, 1);
  endtask : t_power_up

  // attention held back until 14 data bits after reset
  task automatic t_block_attn();
    bit ok;
    int n;
    int hits;
    i_master.wait_idle(ok);
    guard(ok);
    check("bus_idle", bus_idle, 1'b1);
    @(negedge clk);
    fresh_data = 1'b1;
    @(negedge clk);
    fresh_data = 1'b0;
    hits = 0;
    for (n = 0; n < 4000; n++) begin
      @(negedge clk);
      if (line_oe !== 1'b0) hits++;
    end
    check("attn_blocked", hits, 0);
  endtask : t_block_attn

  task automatic t_write(input int len, input logic exp);
    int v0;
    int s0;
    int low;
    v0 = n_valid;
    s0 = n_start;
    i_master.pulse(len, low);
    guard(low >= 0);
    check("idle_drops", bus_idle, 1'b0);
    repeat (4) @(negedge clk);
    check("wr_count", n_valid - v0, 1);
    check("wr_bit", last_bit, exp);
    check("wr_no_start", n_start - s0, 0);
  endtask : t_write

  task automatic t_read(input logic b);
    int t0;
    int low;
    t0 = n_taken;
    tx_valid = 1'b1;
    tx_bit = b;
    i_master.pulse(3000, low);
    guard(low >= 0);
    repeat (4) @(negedge clk);
    tx_valid = 1'b0;
    check("rd_taken", n_taken - t0, 1);
    check("rd_bit", last_bit, b);
    if (b) begin
      check("rd_one_min", low >= SLAVE_ONE_PULSE_MIN_DUS * CYC_PER_DUS,
            1);
      check("rd_one_max", low <= (SLAVE_ONE_PULSE_MAX_DUS +
            EDGE_DETECT_WINDOW_DUS) * CYC_PER_DUS, 1);
    end else begin
      check("rd_zero_len", low, 3000);
    end
  endtask : t_read

  task automatic t_start(input int len);
    int v0;
    int s0;
    int low;
    v0 = n_valid;
    s0 = n_start;
    i_master.pulse(len, low);
    guard(low >= 0);
    repeat (4) @(negedge clk);
    check("start_seen", n_start - s0, 1);
    check("start_no_bit", n_valid - v0, 0);
  endtask : t_start

  // pending attention goes out once 14 bits have passed
  task automatic t_attn();
    int gap;
    int low;
    int v0;
    int a0;
    v0 = n_valid;
    a0 = n_attn;
    i_master.watch_low(IDLE_CYC + 4000, gap, low);
    guard(low >= 0);
    repeat (4) @(negedge clk);
    check("attn_seen", n_attn - a0, 1);
    check("attn_after_idle", gap >= IDLE_CYC - 10, 1);
    check("attn_min", low >= ATTENTION_PULSE_MIN_DUS * CYC_PER_DUS,
          1);
    check("attn_max", low <= ATTENTION_PULSE_MAX_DUS * CYC_PER_DUS,
          1);
    check("attn_no_bit", n_valid - v0, 0);
  endtask : t_attn

  task automatic t_reset();
    int a0;
    int r0;
    int low;
    a0 = n_attn;
    r0 = n_reset;
    i_master.pulse(RESET_CYC + 200, low);
    guard(low >= 0);
    repeat (4) @(negedge clk);
    check("reset_seen", n_reset - r0, 1);
    check("reset_not_attn", n_attn - a0, 0);
    addr_sel = 1'b1;
    repeat (4) @(negedge clk);
    check("dev_num_high", dev_num, DEV_NUM_PIN_HIGH);
  endtask : t_reset

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    addr_sel = 1'b0;
    tx_valid = 1'b0;
    tx_bit = 1'b0;
    fresh_data = 1'b0;
    t_power_up();
    t_block_attn();
    t_write(2950, 1'b0);
    t_write(4250, 1'b0);
    t_write(8850, 1'b1);
    t_write(12225, 1'b1);
    t_read(1'b1);
    t_read(1'b0);
    t_start(20000);
    t_start(27250);
    for (int i = 0; i < 8; i++) t_write(3000, 1'b0);
    t_attn();
    t_reset();
    tally_and_finish();
  end
endmodule : test_swp_slave
`default_nettype wire
